// [fnsl_pkg.sv]
// fnsl_pkg: constants for the fractional-n synthesiser load and lock block
// assumes one 10 MHz core clock and an axi4-lite register port
//
// What this block does
// - control bit 8 enables the synthesiser; device powers it when set
// - charge pump stays high impedance until dividers loaded in order
// - after correct loading synthesiser runs; later rewrites follow mode order
// - integer-n: integer divider write applies new ratio at once
// - 16-bit fractional: ratio applies on low fraction write; high fraction ignored
// - 24-bit fractional: integer and high fraction staged, applied on low write
// - every applied ratio starts fastlock if fastlock is enabled
// - control bit 14 picks 16/24-bit; bits 13-11 pick modulator type
// - lock config bit 14: 0 digital detector, 1 analogue detector
// - digital phase error is time between reference and feedback rising edges
// - each comparison gives in-phase pulse inside window, miss pulse otherwise
// - lock after consecutive in-phase pulses equal to bits 4-0
// - unlock after consecutive miss pulses equal to bits 7-5
// - unlocked window width is lock window bits 10-8
// - locked window widened by multiplier in bits 12-11
// - selected detector lock state reported in status register
// - analogue error pulse from first rising input to other input's rise
// - analogue lock rises above upper threshold, falls below lower one
// - analogue bits 3-0 set charge time from zero to upper threshold
// - analogue bits 6-4 set discharge rate as multiple above charge rate
// - status bit 7 shows lock directly, 1 in lock, host may poll
package fnsl_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SYNTH_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_LOCK_DETECT_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_FASTLOCK_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_REFERENCE_DIVIDER = 8'h0c;
  localparam logic [7:0] ADDR_INTEGER_DIVIDER = 8'h10;
  localparam logic [7:0] ADDR_FRACTION_LOW = 8'h14;
  localparam logic [7:0] ADDR_FRACTION_HIGH = 8'h18;
  localparam logic [7:0] ADDR_SYNTH_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_ACTIVE_RATIO = 8'h20;
  // reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_LOCKDET = 16'h0000;
  localparam logic [15:0] RST_FASTLOCK = 16'h0000;
  localparam logic [7:0] RST_REFDIV = 8'h00;
  localparam logic [10:0] RST_INTDIV = 11'h020;
  localparam logic [15:0] RST_FRAC_LOW = 16'h0000;
  localparam logic [7:0] RST_FRAC_HIGH = 8'h00;
  // field positions
  localparam int CTL_ENABLE_BIT = 8;
  localparam int CTL_RES16_BIT = 14;
  localparam int CTL_MOD_LSB = 11;
  localparam int LD_ANALOGUE_BIT = 14;
  localparam int LD_LOCK_THR_LSB = 0;
  localparam int LD_LOSS_THR_LSB = 5;
  localparam int LD_WINDOW_LSB = 8;
  localparam int LD_MULT_LSB = 11;
  localparam int LD_CHARGE_LSB = 0;
  localparam int LD_DISCH_LSB = 4;
  localparam int FL_ENABLE_BIT = 15;
  localparam int STAT_LOCK_BIT = 7;
  // modulator type codes
  localparam logic [2:0] MOD_TYPE_A = 3'h1;
  localparam logic [2:0] MOD_TYPE_B = 3'h6;
  // fastlock duration in core cycles
  localparam int FASTLOCK_CYCLES = 1024;
  // analogue integrator scale: upper and lower thresholds
  localparam logic [15:0] CAP_UPPER = 16'hc000;
  localparam logic [15:0] CAP_LOWER = 16'h4000;
endpackage

// [fnsl_lock_detect.sv]
// fnsl_lock_detect: digital and analogue lock detectors for one channel
// assumes reference and feedback divider edges as one-cycle pulses at core clock
`timescale 1ns/1ns
module fnsl_lock_detect (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic [15:0] lock_detect_config_i,
  input wire logic restart_i,
  // divider edges
  input wire logic ref_edge_i,
  input wire logic fb_edge_i,
  // result
  output logic lock_o,
  output logic window_miss_pulse_o,
  output logic in_phase_pulse_o
);
  logic analogue;
  logic [4:0] lock_thr;
  logic [2:0] loss_thr;
  logic [2:0] win_base;
  logic [1:0] win_mult;
  logic [3:0] charge_sel;
  logic [2:0] disch_sel;
  logic [7:0] err_cnt_reg;
  logic meas_reg;
  logic first_ref_reg;
  logic [7:0] window;
  logic [4:0] in_cnt_reg;
  logic [2:0] miss_cnt_reg;
  logic dig_lock_reg;
  logic [15:0] cap_reg;
  logic ana_lock_reg;
  logic both;
  logic done;
  logic [15:0] charge_step;
  logic [15:0] disch_step;

  assign analogue = lock_detect_config_i[fnsl_pkg::LD_ANALOGUE_BIT];
  assign lock_thr = lock_detect_config_i[fnsl_pkg::LD_LOCK_THR_LSB +: 5];
  assign loss_thr = lock_detect_config_i[fnsl_pkg::LD_LOSS_THR_LSB +: 3];
  assign win_base = lock_detect_config_i[fnsl_pkg::LD_WINDOW_LSB +: 3];
  assign win_mult = lock_detect_config_i[fnsl_pkg::LD_MULT_LSB +: 2];
  assign charge_sel = lock_detect_config_i[fnsl_pkg::LD_CHARGE_LSB +: 4];
  assign disch_sel = lock_detect_config_i[fnsl_pkg::LD_DISCH_LSB +: 3];

  // window in core cycles; widened while locked
  assign window = dig_lock_reg ? 8'({5'h0, win_base} * {6'h0, win_mult} + {5'h0, win_base} + 8'h1)
                               : {5'h0, win_base} + 8'h1;
  assign both = ref_edge_i & fb_edge_i;
  assign done = meas_reg & (ref_edge_i | fb_edge_i);

  // error from first rising edge to the other
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i | restart_i) begin
      meas_reg <= 1'b0;
      err_cnt_reg <= 8'h00;
      first_ref_reg <= 1'b0;
    end else if (both) begin
      meas_reg <= 1'b0;
      err_cnt_reg <= 8'h00;
    end else if (done) begin
      meas_reg <= 1'b0;
    end else if (ref_edge_i | fb_edge_i) begin
      meas_reg <= 1'b1;
      first_ref_reg <= ref_edge_i;
      err_cnt_reg <= 8'h00;
    end else if (meas_reg && err_cnt_reg != 8'hff) begin
      err_cnt_reg <= err_cnt_reg + 8'h1;
    end
  end

  assign in_phase_pulse_o = both | (done & (err_cnt_reg < window));
  assign window_miss_pulse_o = done & (err_cnt_reg >= window);

  // consecutive counts and digital lock state
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i | restart_i) begin
      in_cnt_reg <= 5'h00;
      miss_cnt_reg <= 3'h0;
      dig_lock_reg <= 1'b0;
    end else if (in_phase_pulse_o) begin
      miss_cnt_reg <= 3'h0;
      if (!dig_lock_reg && in_cnt_reg + 5'h1 >= lock_thr) begin
        dig_lock_reg <= 1'b1;
        in_cnt_reg <= 5'h00;
      end else if (in_cnt_reg != 5'h1f) begin
        in_cnt_reg <= in_cnt_reg + 5'h1;
      end
    end else if (window_miss_pulse_o) begin
      in_cnt_reg <= 5'h00;
      if (dig_lock_reg && miss_cnt_reg + 3'h1 >= loss_thr) begin
        dig_lock_reg <= 1'b0;
        miss_cnt_reg <= 3'h0;
      end else if (miss_cnt_reg != 3'h7) begin
        miss_cnt_reg <= miss_cnt_reg + 3'h1;
      end
    end
  end

  // capacitor model: charge while no error, discharge faster while error
  assign charge_step = 16'h0010 << charge_sel;
  assign disch_step = charge_step * (16'h2 + {13'h0, disch_sel});
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i | restart_i) begin
      cap_reg <= 16'h0000;
    end else if (meas_reg) begin
      cap_reg <= (cap_reg > disch_step) ? cap_reg - disch_step : 16'h0000;
    end else begin
      cap_reg <= (16'hffff - cap_reg > charge_step) ? cap_reg + charge_step : 16'hffff;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i | restart_i) begin
      ana_lock_reg <= 1'b0;
    end else if (cap_reg > fnsl_pkg::CAP_UPPER) begin
      ana_lock_reg <= 1'b1;
    end else if (cap_reg < fnsl_pkg::CAP_LOWER) begin
      ana_lock_reg <= 1'b0;
    end
  end

  assign lock_o = analogue ? ana_lock_reg : dig_lock_reg;
endmodule // fnsl_lock_detect

// [fnsl_top.sv]
// fnsl_top: divider load ordering, ratio apply, fastlock and lock status
// assumes an axi4-lite master on core_clk_i and divider edges from the synth
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module fnsl_top #(
  parameter int FASTLOCK_CYCLES = fnsl_pkg::FASTLOCK_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // divider edges
  input wire logic ref_edge_i,
  input wire logic fb_edge_i,
  // synthesiser controls
  output logic synth_power_o,
  output logic cp_drive_o,
  output logic fastlock_o,
  output logic [10:0] active_int_o,
  output logic [23:0] active_frac_o,
  output logic frac_mode_o,
  output logic [2:0] mod_type_o,
  output logic ratio_apply_o,
  output logic lock_o
);
  logic [15:0] synth_control_reg;
  logic [15:0] lock_detect_config_reg;
  logic [15:0] fastlock_config_reg;
  logic [7:0] reference_divider_reg;
  logic [10:0] integer_divider_reg;
  logic [15:0] fraction_low_reg;
  logic [7:0] fraction_high_reg;
  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic do_write;
  logic wr_ok;
  logic [15:0] wval;
  logic int_mode;
  logic res16;
  logic apply;
  logic loaded_reg;
  logic [31:0] fl_cnt_reg;
  logic restart;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = a == fnsl_pkg::ADDR_SYNTH_CONTROL || a == fnsl_pkg::ADDR_LOCK_DETECT_CONFIG ||
            a == fnsl_pkg::ADDR_FASTLOCK_CONFIG || a == fnsl_pkg::ADDR_REFERENCE_DIVIDER ||
            a == fnsl_pkg::ADDR_INTEGER_DIVIDER || a == fnsl_pkg::ADDR_FRACTION_LOW ||
            a == fnsl_pkg::ADDR_FRACTION_HIGH || a == fnsl_pkg::ADDR_SYNTH_STATUS ||
            a == fnsl_pkg::ADDR_ACTIVE_RATIO;
  endfunction

  // write channel capture
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign do_write = aw_held_reg & w_held_reg & !s_axi_bvalid;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end
  assign wr_ok = known(aw_addr_reg) && aw_addr_reg != fnsl_pkg::ADDR_SYNTH_STATUS &&
                 aw_addr_reg != fnsl_pkg::ADDR_ACTIVE_RATIO;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register file
  // low fraction as it stands after the pending write, sign taken from the merged word
  assign wval = merge16(fraction_low_reg, w_data_reg, w_strb_reg);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      synth_control_reg <= fnsl_pkg::RST_CONTROL;
      lock_detect_config_reg <= fnsl_pkg::RST_LOCKDET;
      fastlock_config_reg <= fnsl_pkg::RST_FASTLOCK;
      reference_divider_reg <= fnsl_pkg::RST_REFDIV;
      integer_divider_reg <= fnsl_pkg::RST_INTDIV;
      fraction_low_reg <= fnsl_pkg::RST_FRAC_LOW;
      fraction_high_reg <= fnsl_pkg::RST_FRAC_HIGH;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        fnsl_pkg::ADDR_SYNTH_CONTROL:
          synth_control_reg <= merge16(synth_control_reg, w_data_reg, w_strb_reg);
        fnsl_pkg::ADDR_LOCK_DETECT_CONFIG:
          lock_detect_config_reg <= merge16(lock_detect_config_reg, w_data_reg, w_strb_reg);
        fnsl_pkg::ADDR_FASTLOCK_CONFIG:
          fastlock_config_reg <= merge16(fastlock_config_reg, w_data_reg, w_strb_reg);
        fnsl_pkg::ADDR_REFERENCE_DIVIDER: begin
          if (w_strb_reg[0]) reference_divider_reg <= {1'b0, w_data_reg[6:0]};
        end
        fnsl_pkg::ADDR_INTEGER_DIVIDER:
          integer_divider_reg <= 11'(merge16({5'h00, integer_divider_reg}, w_data_reg,
                                             w_strb_reg));
        fnsl_pkg::ADDR_FRACTION_LOW:
          fraction_low_reg <= merge16(fraction_low_reg, w_data_reg, w_strb_reg);
        fnsl_pkg::ADDR_FRACTION_HIGH: begin
          if (w_strb_reg[0]) fraction_high_reg <= w_data_reg[7:0];
        end
        default: ;
      endcase
    end
  end

  // mode decode and ratio apply point
  assign res16 = synth_control_reg[fnsl_pkg::CTL_RES16_BIT];
  assign mod_type_o = synth_control_reg[fnsl_pkg::CTL_MOD_LSB +: 3];
  assign int_mode = mod_type_o != fnsl_pkg::MOD_TYPE_A && mod_type_o != fnsl_pkg::MOD_TYPE_B &&
                    mod_type_o == 3'h0;
  assign frac_mode_o = !int_mode;
  assign apply = do_write & (int_mode ? aw_addr_reg == fnsl_pkg::ADDR_INTEGER_DIVIDER
                                      : aw_addr_reg == fnsl_pkg::ADDR_FRACTION_LOW);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      active_int_o <= fnsl_pkg::RST_INTDIV;
      active_frac_o <= 24'h000000;
      ratio_apply_o <= 1'b0;
    end else begin
      ratio_apply_o <= apply;
      if (apply) begin
        if (int_mode) begin
          active_int_o <= 11'(merge16({5'h00, integer_divider_reg}, w_data_reg,
                                      w_strb_reg));
          active_frac_o <= 24'h000000;
        end else if (res16) begin
          active_int_o <= integer_divider_reg;
          active_frac_o <= {{8{wval[15]}}, wval};
        end else begin
          active_int_o <= integer_divider_reg;
          active_frac_o <= {fraction_high_reg, wval};
        end
      end
    end
  end

  // charge pump release after first correct load
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      loaded_reg <= 1'b0;
    end else if (apply) begin
      loaded_reg <= 1'b1;
    end
  end
  assign synth_power_o = synth_control_reg[fnsl_pkg::CTL_ENABLE_BIT];
  assign cp_drive_o = synth_power_o & loaded_reg;

  // fastlock timer
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fl_cnt_reg <= 32'h0000_0000;
    end else if (apply && fastlock_config_reg[fnsl_pkg::FL_ENABLE_BIT]) begin
      fl_cnt_reg <= 32'(FASTLOCK_CYCLES);
    end else if (fl_cnt_reg != 32'h0000_0000) begin
      fl_cnt_reg <= fl_cnt_reg - 32'h1;
    end
  end
  assign fastlock_o = fl_cnt_reg != 32'h0000_0000;

  // detectors restart while the loop is not running
  assign restart = !cp_drive_o;
  fnsl_lock_detect fnsl_lock_detect_i (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .lock_detect_config_i(lock_detect_config_reg),
    .restart_i(restart),
    .ref_edge_i(ref_edge_i),
    .fb_edge_i(fb_edge_i),
    .lock_o(lock_o),
    .window_miss_pulse_o(),
    .in_phase_pulse_o()
  );

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
      unique case ({s_axi_araddr[7:2], 2'b00})
        fnsl_pkg::ADDR_SYNTH_CONTROL: s_axi_rdata <= {16'h0000, synth_control_reg};
        fnsl_pkg::ADDR_LOCK_DETECT_CONFIG: s_axi_rdata <= {16'h0000, lock_detect_config_reg};
        fnsl_pkg::ADDR_FASTLOCK_CONFIG: s_axi_rdata <= {16'h0000, fastlock_config_reg};
        fnsl_pkg::ADDR_REFERENCE_DIVIDER: s_axi_rdata <= {24'h000000, reference_divider_reg};
        fnsl_pkg::ADDR_INTEGER_DIVIDER: s_axi_rdata <= {21'h000000, integer_divider_reg};
        fnsl_pkg::ADDR_FRACTION_LOW: s_axi_rdata <= {16'h0000, fraction_low_reg};
        fnsl_pkg::ADDR_FRACTION_HIGH: s_axi_rdata <= {24'h000000, fraction_high_reg};
        fnsl_pkg::ADDR_SYNTH_STATUS: s_axi_rdata <= {24'h000000, lock_o, 2'b00, fastlock_o,
                                                     cp_drive_o, 3'b000};
        fnsl_pkg::ADDR_ACTIVE_RATIO: s_axi_rdata <= {active_frac_o[15:0], 5'h00, active_int_o};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // fnsl_top

// [fnsl_top_asserts.sv]
// fnsl_top_asserts: port checks of ratio apply, fastlock, pump release and lock status
// assumes binding to fnsl_top on its single core clock and low-active reset
`timescale 1ns/1ns
module fnsl_top_asserts #(
  parameter int FASTLOCK_CYCLES = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // read port
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // synthesiser controls
  input wire logic cp_drive_o,
  input wire logic fastlock_o,
  input wire logic [10:0] active_int_o,
  input wire logic [23:0] active_frac_o,
  input wire logic frac_mode_o,
  input wire logic [2:0] mod_type_o,
  input wire logic ratio_apply_o,
  input wire logic lock_o
);
  logic [7:0] rd_addr_reg;
  int fl_cnt_reg;
  logic loaded_reg;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) rd_addr_reg <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !fastlock_o) fl_cnt_reg <= 0;
    else fl_cnt_reg <= fl_cnt_reg + 1;
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) loaded_reg <= 1'b0;
    else if (ratio_apply_o) loaded_reg <= 1'b1;
  end
  fastlock_len_a: assert property (
    fastlock_o |-> fl_cnt_reg < FASTLOCK_CYCLES) else $error("fastlock too long");
  fastlock_end_a: assert property (
    $fell(fastlock_o) |-> fl_cnt_reg == FASTLOCK_CYCLES) else $error("fastlock too short");
  fastlock_cause_a: assert property (
    $rose(fastlock_o) |-> ratio_apply_o || $past(ratio_apply_o)) else $error("stray fastlock");
  pump_wait_a: assert property (
    cp_drive_o |-> loaded_reg || ratio_apply_o) else $error("pump driven before load");
  apply_pulse_a: assert property (
    ratio_apply_o |=> !ratio_apply_o) else $error("apply pulse too long");
  ratio_hold_a: assert property (
    $changed(active_int_o) || $changed(active_frac_o) |-> ratio_apply_o or ##1 ratio_apply_o)
    else $error("ratio changed without apply");
  frac_mode_a: assert property (
    frac_mode_o == (mod_type_o != 3'h0)) else $error("mode flag mismatch");
  status_lock_a: assert property (
    s_axi_rvalid && !$past(s_axi_rvalid) && rd_addr_reg == fnsl_pkg::ADDR_SYNTH_STATUS
    |-> s_axi_rdata[7] == $past(lock_o)) else $error("status lock bit wrong");
  lock_idle_a: assert property (
    !cp_drive_o [*2] |-> !lock_o) else $error("lock while pump idle");
endmodule // fnsl_top_asserts

// [fnsl_divider_model.sv]
// fnsl_divider_model: reference and feedback divider edges seen by the lock detectors
// assumes one-cycle edge pulses; new settings are taken only at a period start
`timescale 1ns/1ns
module fnsl_divider_model #(
  parameter int PERIOD = 16
) (
  // clock and pattern
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic [3:0] skew_i,
  input wire logic alt_i,
  // divider edges
  output logic ref_edge_o,
  output logic fb_edge_o
);
  int phase;
  int slot;
  logic [3:0] skew_reg;
  logic alt_reg;
  always_ff @(posedge core_clk_i) begin
    if (!run_i || phase == PERIOD - 1) begin
      // idle parks at period end so the first period after start uses fresh settings
      phase <= run_i ? 0 : PERIOD - 1;
      skew_reg <= skew_i;
      alt_reg <= alt_i;
      slot <= (slot == 2) ? 0 : slot + 1;
    end else begin
      phase <= phase + 1;
    end
  end
  // alternating mode skews only every third feedback edge
  assign ref_edge_o = run_i && phase == 0;
  assign fb_edge_o = run_i && phase == ((alt_reg && slot != 2) ? 0 : int'(skew_reg));
endmodule // fnsl_divider_model

// [fnsl_top_test.sv]
// fnsl_top_test: register-driven test of load order, apply, fastlock and both detectors
// assumes fnsl_top with a short fastlock and the divider model on its edge inputs
`timescale 1ns/1ns
module fnsl_top_test;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic run = 1'b0;
  logic [3:0] skew = 4'h0;
  logic alt = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic ref_edge_i, fb_edge_i, synth_power_o, cp_drive_o, fastlock_o, frac_mode_o;
  logic ratio_apply_o, lock_o;
  logic [10:0] active_int_o;
  logic [23:0] active_frac_o;
  logic [2:0] mod_type_o;
  int fail_count = 0;
  int check_count = 0;
  always #50 core_clk_i = ~core_clk_i;
  fnsl_top #(.FASTLOCK_CYCLES(8)) fnsl_top_i (.*);
  fnsl_divider_model fnsl_divider_model_i (.core_clk_i(core_clk_i), .run_i(run),
    .skew_i(skew), .alt_i(alt), .ref_edge_o(ref_edge_i), .fb_edge_o(fb_edge_i));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge core_clk_i);
      if (s_axi_awready === 1'b1) pa = 1'b0;
      if (s_axi_wready === 1'b1) pw = 1'b0;
      @(posedge core_clk_i);
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge core_clk_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge core_clk_i); while (s_axi_arready !== 1'b1);
    @(posedge core_clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge core_clk_i);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pat(input logic [3:0] s, input logic a);
    @(posedge core_clk_i);
    skew <= s;
    alt <= a;
    run <= 1'b1;
  endtask
  task automatic hold(input logic v, input int n);
    logic seen;
    seen = v;
    repeat (n) begin
      @(negedge core_clk_i);
      if (lock_o !== v) seen = lock_o;
    end
    check("lock held", seen, v);
  endtask
  task automatic wait_lock(input logic v);
    int i;
    i = 0;
    while (lock_o !== v && i < 1500) begin
      @(negedge core_clk_i);
      i++;
    end
    check("lock", lock_o, v);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h020);
    rd(fnsl_pkg::ADDR_SYNTH_STATUS);
    check("status", rdat, 32'h0);
    rd(8'h24);
    check("rresp", resp, 2'b10);
    wr(8'h24, 32'h1);
    check("bresp", resp, 2'b10);
    wr(fnsl_pkg::ADDR_SYNTH_CONTROL, 32'h0100);
    wr(fnsl_pkg::ADDR_LOCK_DETECT_CONFIG, 32'h0943);
    wr(fnsl_pkg::ADDR_FASTLOCK_CONFIG, 32'h8000);
    wr(fnsl_pkg::ADDR_REFERENCE_DIVIDER, 32'h08);
    @(negedge core_clk_i);
    check("power", synth_power_o, 1'b1);
    check("pump", cp_drive_o, 1'b0);
    wr(fnsl_pkg::ADDR_INTEGER_DIVIDER, 32'h14f);
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h14f);
    check("pump", cp_drive_o, 1'b1);
    check("fastlock", fastlock_o, 1'b1);
    wr(fnsl_pkg::ADDR_SYNTH_CONTROL, 32'h4900);
    wr(fnsl_pkg::ADDR_INTEGER_DIVIDER, 32'h139);
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h14f);
    check("mode", mod_type_o, 3'h1);
    wr(fnsl_pkg::ADDR_FRACTION_HIGH, 32'h12);
    wr(fnsl_pkg::ADDR_FRACTION_LOW, 32'h8000);
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h139);
    check("frac", active_frac_o, 24'hff8000);
    wr(fnsl_pkg::ADDR_FASTLOCK_CONFIG, 32'h0);
    wr(fnsl_pkg::ADDR_SYNTH_CONTROL, 32'h3100);
    wr(fnsl_pkg::ADDR_INTEGER_DIVIDER, 32'h3e4);
    wr(fnsl_pkg::ADDR_FRACTION_HIGH, 32'h2c);
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h139);
    wr(fnsl_pkg::ADDR_FRACTION_LOW, 32'h25ed);
    @(negedge core_clk_i);
    check("int", active_int_o, 11'h3e4);
    check("frac", active_frac_o, 24'h2c25ed);
    check("fastlock", fastlock_o, 1'b0);
    check("mode", mod_type_o, 3'h6);
    check("frac mode", frac_mode_o, 1'b1);
    pat(4'h8, 1'b1);
    hold(1'b0, 400);
    pat(4'h0, 1'b0);
    wait_lock(1'b1);
    rd(fnsl_pkg::ADDR_SYNTH_STATUS);
    check("status lock", rdat[7], 1'b1);
    pat(4'h8, 1'b1);
    hold(1'b1, 400);
    pat(4'h3, 1'b0);
    hold(1'b1, 200);
    pat(4'h8, 1'b0);
    wait_lock(1'b0);
    pat(4'h3, 1'b0);
    hold(1'b0, 400);
    wr(fnsl_pkg::ADDR_LOCK_DETECT_CONFIG, 32'h4004);
    pat(4'h8, 1'b0);
    wait_lock(1'b0);
    pat(4'h0, 1'b0);
    wait_lock(1'b1);
    pat(4'h8, 1'b0);
    wait_lock(1'b0);
    report_and_stop();
  end
endmodule // fnsl_top_test
bind fnsl_top fnsl_top_asserts #(.FASTLOCK_CYCLES(FASTLOCK_CYCLES)) fnsl_top_asserts_i (.*);
